// ===== rtl/fault_sup_pkg.sv
// constants shared by the regulator fault supervisor and its helpers
// assumes a single 125 MHz system clock; the qualification and diode target cycle counts derive from it
package fault_sup_pkg;
    localparam int          CLK_MHZ        = 125;
    localparam int          OC_QUAL_NS     = 120000;
    localparam int          QUAL_NS        = 1000000;
    localparam int          DIODE_TGT_NS   = 40;
    localparam int          CNT_W          = 17;
    localparam logic [16:0] OC_QUAL_CYC    = 17'(OC_QUAL_NS * CLK_MHZ / 1000);
    localparam logic [16:0] QUAL_CYC       = 17'(QUAL_NS * CLK_MHZ / 1000);
    localparam logic [3:0]  DIODE_TGT_CYC  = 4'(DIODE_TGT_NS * CLK_MHZ / 1000);
    localparam logic [3:0]  DIODE_CAP_CYC  = 4'hf;
    localparam logic [11:0] SS_CYC         = 12'h400;
    // apb map
    localparam logic [7:0]  CTRL_ADDR      = 8'h00;
    localparam logic [7:0]  STATUS_ADDR    = 8'h04;
    // ctrl fields
    localparam int          CTRL_PHCFG_LSB = 0;
    localparam int          CTRL_OVS_BIT   = 2;
    localparam logic [2:0]  CTRL_RESET     = 3'h2;
    // phase configuration codes
    localparam logic [1:0]  PHCFG_ONE      = 2'h0;
    localparam logic [1:0]  PHCFG_TWO      = 2'h1;
    localparam logic [1:0]  PHCFG_THREE    = 2'h2;
    // trip level scale codes
    localparam logic [1:0]  SCALE_FULL     = 2'h0;
    localparam logic [1:0]  SCALE_TWO_3RD  = 2'h1;
    localparam logic [1:0]  SCALE_HALF     = 2'h2;
    localparam logic [1:0]  SCALE_ONE_3RD  = 2'h3;
    // status fields
    localparam int          ST_FAULT_LSB   = 0;
    localparam int          ST_OV2_BIT     = 5;
    localparam int          ST_OT_BIT      = 6;
    localparam int          ST_STATE_LSB   = 7;
    localparam int          ST_TRIM_LSB    = 10;
    // latched fault vector positions
    localparam int          F_OC           = 0;
    localparam int          F_IMB          = 1;
    localparam int          F_UV           = 2;
    localparam int          F_OV1          = 3;
    localparam int          F_WOC          = 4;
    localparam int          NQUAL          = 4;
    localparam int          NSYNC          = 20;
    localparam logic [5:0]  TRIM_RESET     = 6'h20;
    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_SOFT    = 3'h1,
        ST_RUN     = 3'h3,
        ST_FAULT   = 3'h2,
        ST_OV2_DIS = 3'h6,
        ST_OV2_OFF = 3'h7
    } state_type;
endpackage

// ===== rtl/flag_sync.sv
// two-stage synchroniser for a bundle of comparator flags
// assumes flags are quasi-static relative to mclk_i
`timescale 1ns/1ps
module flag_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_i,
    input  wire logic         reset_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] flag_i,
    output logic      [W-1:0] flag_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce_i) begin
            meta_ff <= flag_i;
            sync_ff <= meta_ff;
        end
    end

    assign flag_o = sync_ff;
endmodule // flag_sync

// ===== rtl/qual_timer.sv
// duration qualifier: hit_o rises once cond_i has held for tc_i cycles
// assumes cond_i is already synchronous to mclk_i
`timescale 1ns/1ps
module qual_timer (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic        arm_i,
    input  wire logic        cond_i,
    input  wire logic [16:0] tc_i,
    output logic             hit_o
);
    logic [16:0] cnt_ff;
    logic [16:0] nxt_cnt;
    logic        hit_ff;
    logic        run_w;
    logic        done_w;

    assign run_w  = arm_i && cond_i;
    assign done_w = (cnt_ff >= tc_i - 17'h00001);
    // any gap in the condition restarts the count
    assign nxt_cnt = !run_w ? 17'h00000 : (done_w ? cnt_ff : cnt_ff + 17'h00001);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cnt_ff <= 17'h00000;
            hit_ff <= 1'b0;
        end else if (ce_i) begin
            cnt_ff <= nxt_cnt;
            hit_ff <= run_w && done_w;
        end
    end

    assign hit_o = hit_ff;

    AST_QUAL_RESTART: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && !cond_i |=> cnt_ff == 17'h00000 && !hit_o)
        else $error("qualifier did not restart on a gap");
    AST_QUAL_LEN: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(hit_o) |-> $past(cnt_ff) == tc_i - 17'h00001)
        else $error("qualifier fired before full interval");
endmodule // qual_timer

// ===== rtl/regulator_fault_supervisor.sv
// file: top of the supervisor with apb control/status registers
// assumes comparator flags and modulator gate requests arrive as digital levels
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module regulator_fault_supervisor #(
    parameter logic [16:0] OC_QUAL_CYC = fault_sup_pkg::OC_QUAL_CYC,
    parameter logic [16:0] QUAL_CYC    = fault_sup_pkg::QUAL_CYC
) (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        regulator_enable_in_i,
    input  wire logic        supply_ok_i,
    input  wire logic        low_power_state_n_i,
    input  wire logic        deep_sleep_i,
    input  wire logic        overcurrent_trip_i,
    input  wire logic        way_overcurrent_i,
    input  wire logic        imbalance_i,
    input  wire logic        undervoltage_trip_i,
    input  wire logic        overvoltage_trip_i,
    input  wire logic        ov_abs_high_i,
    input  wire logic        ov_abs_release_i,
    input  wire logic        over_temp_i,
    input  wire logic        comp_clamp_i,
    input  wire logic        zero_cross_i,
    input  wire logic        phase_diode_i,
    input  wire logic        vid_down_i,
    input  wire logic        vout_near_vid_i,
    input  wire logic        pwm_low_req_i,
    input  wire logic        pwm_high_req_i,
    output logic             output_ok_flag_o,
    output logic             pwm_tristate_o,
    output logic             high_side_gate_o,
    output logic             low_side_gate_a_o,
    output logic             low_side_gate_b_o,
    output logic             thermal_throttle_n_o,
    output logic             aux_fb_switch_o,
    output logic             soft_start_o,
    output logic      [1:0]  trip_scale_o,
    output logic      [5:0]  zc_trim_o
);
    // synchronised inputs
    logic [fault_sup_pkg::NSYNC-1:0] raw_w;
    logic [fault_sup_pkg::NSYNC-1:0] s_w;
    assign raw_w = {pwm_high_req_i, pwm_low_req_i, vout_near_vid_i, vid_down_i,
                    phase_diode_i, zero_cross_i, comp_clamp_i, over_temp_i,
                    ov_abs_release_i, ov_abs_high_i, overvoltage_trip_i,
                    undervoltage_trip_i, imbalance_i, way_overcurrent_i,
                    overcurrent_trip_i, deep_sleep_i, low_power_state_n_i,
                    supply_ok_i, regulator_enable_in_i, 1'b0};

    flag_sync #(.W(fault_sup_pkg::NSYNC)) u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .flag_i  (raw_w),
        .flag_o  (s_w)
    );

    logic en_s, por_s, lps_n_s, dslp_s, oc_s, woc_s, imb_s, uv_s, ov1_s;
    logic ov2_s, rel_s, ot_s, clamp_s, zc_s, diode_s, vdn_s, near_s, lreq_s, hreq_s;
    assign {hreq_s, lreq_s, near_s, vdn_s, diode_s, zc_s, clamp_s, ot_s, rel_s, ov2_s,
            ov1_s, uv_s, imb_s, woc_s, oc_s, dslp_s, lps_n_s, por_s, en_s} = s_w[19:1];

    // apb registers
    logic [2:0]  ctrl_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        setup_w;
    logic        access_w;
    logic        hit_ctrl_w;
    logic        hit_stat_w;
    logic [31:0] rdata_w;
    logic [31:0] status_w;

    assign setup_w    = psel_i && !penable_i;
    assign access_w   = psel_i && penable_i && pready_ff;
    assign hit_ctrl_w = (paddr_i == fault_sup_pkg::CTRL_ADDR);
    assign hit_stat_w = (paddr_i == fault_sup_pkg::STATUS_ADDR);
    assign rdata_w    = hit_ctrl_w ? {29'h0, ctrl_ff} : (hit_stat_w ? status_w : 32'h0);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl_ff    <= fault_sup_pkg::CTRL_RESET;
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (ce_i) begin
            pready_ff  <= setup_w;
            pslverr_ff <= setup_w && !hit_ctrl_w && !hit_stat_w;
            prdata_ff  <= setup_w && !pwrite_i ? rdata_w : 32'h0;
            if (access_w && pwrite_i && hit_ctrl_w) begin
                ctrl_ff <= pwdata_i[2:0];
            end
        end
    end

    logic [1:0] phcfg_w;
    logic       ovs_cfg_w;
    assign phcfg_w   = ctrl_ff[fault_sup_pkg::CTRL_PHCFG_LSB +: 2];
    assign ovs_cfg_w = ctrl_ff[fault_sup_pkg::CTRL_OVS_BIT];

    // operating mode
    logic two_ph_op_w;
    logic three_ph_op_w;
    logic de_mode_w;
    logic [1:0] nxt_scale;
    assign de_mode_w     = dslp_s;
    assign three_ph_op_w = (phcfg_w == fault_sup_pkg::PHCFG_THREE) && lps_n_s && !dslp_s;
    assign two_ph_op_w   = !dslp_s && ((phcfg_w == fault_sup_pkg::PHCFG_TWO && lps_n_s)
                          || (phcfg_w == fault_sup_pkg::PHCFG_THREE && !lps_n_s));
    assign nxt_scale = dslp_s && phcfg_w != fault_sup_pkg::PHCFG_ONE ?
                           fault_sup_pkg::SCALE_ONE_3RD :
                       (phcfg_w == fault_sup_pkg::PHCFG_THREE && !lps_n_s) ?
                           fault_sup_pkg::SCALE_TWO_3RD :
                       (phcfg_w == fault_sup_pkg::PHCFG_TWO && !lps_n_s) ?
                           fault_sup_pkg::SCALE_HALF : fault_sup_pkg::SCALE_FULL;

    // fault qualification
    fault_sup_pkg::state_type state_ff, nxt_state;
    logic [4:0]  fault_ff;
    logic [4:0]  nxt_fault;
    logic [3:0]  qcond_w;
    logic [3:0]  qhit_w;
    logic [16:0] qtc_w [fault_sup_pkg::NQUAL];
    logic        arm_w;
    logic        en_w;
    logic        ov_blank_ff;

    assign en_w  = en_s && por_s;
    assign arm_w = en_w && (state_ff == fault_sup_pkg::ST_SOFT
                  || state_ff == fault_sup_pkg::ST_RUN);
    assign qcond_w = {ov1_s && !ov_blank_ff, uv_s, imb_s, oc_s};
    assign qtc_w[fault_sup_pkg::F_OC]  = OC_QUAL_CYC;
    assign qtc_w[fault_sup_pkg::F_IMB] = QUAL_CYC;
    assign qtc_w[fault_sup_pkg::F_UV]  = QUAL_CYC;
    assign qtc_w[fault_sup_pkg::F_OV1] = QUAL_CYC;

    generate
        for (genvar g = 0; g < fault_sup_pkg::NQUAL; g++) begin : g_qual
            qual_timer u_qual (
                .mclk_i  (mclk_i),
                .reset_i (reset_i),
                .ce_i    (ce_i),
                .arm_i   (arm_w),
                .cond_i  (qcond_w[g]),
                .tc_i    (qtc_w[g]),
                .hit_o   (qhit_w[g])
            );
        end
    endgenerate

    // faults set wins over the enable-low clear
    assign nxt_fault = (en_w ? fault_ff : 5'h00)
                     | {woc_s && arm_w, qhit_w};

    // ov blanking during a downward command in diode emulation
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ov_blank_ff <= 1'b0;
        end else if (ce_i) begin
            ov_blank_ff <= de_mode_w && vdn_s ? 1'b1 : (near_s ? 1'b0 : ov_blank_ff);
        end
    end

    // state machine
    logic        ov2_lat_ff;
    logic        ov2_watch_w;
    logic [11:0] ss_cnt_ff;
    assign ov2_watch_w = por_s && (en_s || ov2_lat_ff);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            fault_sup_pkg::ST_OFF:
                nxt_state = en_w ? fault_sup_pkg::ST_SOFT : fault_sup_pkg::ST_OFF;
            fault_sup_pkg::ST_SOFT:
                nxt_state = |fault_ff ? fault_sup_pkg::ST_FAULT :
                    (ss_cnt_ff == fault_sup_pkg::SS_CYC ? fault_sup_pkg::ST_RUN
                                                        : fault_sup_pkg::ST_SOFT);
            fault_sup_pkg::ST_RUN:
                nxt_state = |fault_ff ? fault_sup_pkg::ST_FAULT : fault_sup_pkg::ST_RUN;
            fault_sup_pkg::ST_FAULT:
                nxt_state = en_w ? fault_sup_pkg::ST_FAULT : fault_sup_pkg::ST_OFF;
            fault_sup_pkg::ST_OV2_DIS:
                nxt_state = rel_s ? fault_sup_pkg::ST_OV2_OFF : fault_sup_pkg::ST_OV2_DIS;
            fault_sup_pkg::ST_OV2_OFF:
                nxt_state = fault_sup_pkg::ST_OV2_OFF;
            default:
                nxt_state = fault_sup_pkg::ST_OFF;
        endcase
        if (ov2_watch_w && ov2_s && !rel_s) begin
            nxt_state = fault_sup_pkg::ST_OV2_DIS;
        end
        if (!por_s) begin
            nxt_state = fault_sup_pkg::ST_OFF;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_ff   <= fault_sup_pkg::ST_OFF;
            fault_ff   <= 5'h00;
            ov2_lat_ff <= 1'b0;
            ss_cnt_ff  <= 12'h000;
        end else if (ce_i) begin
            state_ff   <= nxt_state;
            fault_ff   <= nxt_fault;
            ov2_lat_ff <= por_s && (ov2_lat_ff || (ov2_watch_w && ov2_s));
            ss_cnt_ff  <= state_ff == fault_sup_pkg::ST_SOFT ? ss_cnt_ff + 12'h001 : 12'h000;
        end
    end

    // gate control
    logic lg_on_w;
    logic ovs_cut_w;
    logic zc_cut_ff;
    logic run_w;
    logic ov2_dis_w;
    assign run_w     = (state_ff == fault_sup_pkg::ST_SOFT || state_ff == fault_sup_pkg::ST_RUN)
                      && !(|fault_ff) && !ov2_lat_ff;
    assign ov2_dis_w = (state_ff == fault_sup_pkg::ST_OV2_DIS);
    assign ovs_cut_w = ovs_cfg_w && lps_n_s && clamp_s;
    assign lg_on_w   = run_w && lreq_s && !ovs_cut_w && !zc_cut_ff;

    // zero-crossing cut holds for the rest of the low-side pulse
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            zc_cut_ff <= 1'b0;
        end else if (ce_i) begin
            zc_cut_ff <= lreq_s && (zc_cut_ff || (de_mode_w && zc_s));
        end
    end

    // adaptive diode-conduction trim
    logic [3:0] dcnt_ff;
    logic       dmeas_ff;
    logic [5:0] trim_ff;
    logic       lg_fall_w;
    logic       dend_w;
    assign lg_fall_w = low_side_gate_a_o && !lg_on_w && !ov2_dis_w;
    assign dend_w    = dmeas_ff && (!diode_s || dcnt_ff == fault_sup_pkg::DIODE_CAP_CYC);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dcnt_ff  <= 4'h0;
            dmeas_ff <= 1'b0;
            trim_ff  <= fault_sup_pkg::TRIM_RESET;
        end else if (ce_i) begin
            dmeas_ff <= de_mode_w && (lg_fall_w || (dmeas_ff && !dend_w));
            dcnt_ff  <= dmeas_ff && diode_s ? dcnt_ff + 4'h1 : (lg_fall_w ? 4'h0 : dcnt_ff);
            // one step per diode measurement keeps the loop slow and stable
            if (dend_w && dcnt_ff > fault_sup_pkg::DIODE_TGT_CYC && trim_ff != 6'h00) begin
                trim_ff <= trim_ff - 6'h01;
            end else if (dend_w && dcnt_ff < fault_sup_pkg::DIODE_TGT_CYC
                         && trim_ff != 6'h3f) begin
                trim_ff <= trim_ff + 6'h01;
            end
        end
    end

    // registered outputs
    logic ok_ff, tri_ff, hg_ff, lga_ff, lgb_ff, tt_n_ff, aux_ff, ss_ff;
    logic [1:0] scale_ff;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ok_ff    <= 1'b0;
            tri_ff   <= 1'b1;
            hg_ff    <= 1'b0;
            lga_ff   <= 1'b0;
            lgb_ff   <= 1'b0;
            tt_n_ff  <= 1'b1;
            aux_ff   <= 1'b0;
            ss_ff    <= 1'b0;
            scale_ff <= fault_sup_pkg::SCALE_FULL;
        end else if (ce_i) begin
            ok_ff    <= run_w && state_ff == fault_sup_pkg::ST_RUN;
            tri_ff   <= !run_w && !ov2_dis_w;
            hg_ff    <= run_w && hreq_s;
            lga_ff   <= ov2_dis_w || lg_on_w;
            lgb_ff   <= ov2_dis_w || (lg_on_w && phcfg_w != fault_sup_pkg::PHCFG_ONE);
            tt_n_ff  <= !ot_s;
            aux_ff   <= phcfg_w == fault_sup_pkg::PHCFG_TWO && two_ph_op_w;
            ss_ff    <= state_ff == fault_sup_pkg::ST_SOFT;
            scale_ff <= nxt_scale;
        end
    end

    assign status_w = {16'h0, trim_ff, state_ff, ot_s, ov2_lat_ff, fault_ff};

    assign prdata_o             = prdata_ff;
    assign pready_o             = pready_ff;
    assign pslverr_o            = pslverr_ff;
    assign output_ok_flag_o     = ok_ff;
    assign pwm_tristate_o       = tri_ff;
    assign high_side_gate_o     = hg_ff;
    assign low_side_gate_a_o    = lga_ff;
    assign low_side_gate_b_o    = lgb_ff;
    assign thermal_throttle_n_o = tt_n_ff;
    assign aux_fb_switch_o      = aux_ff;
    assign soft_start_o         = ss_ff;
    assign trip_scale_o         = scale_ff;
    assign zc_trim_o            = trim_ff;

    AST_WOC_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && arm_w && woc_s && !ov2_s |-> ##2 pwm_tristate_o && !output_ok_flag_o)
        else $error("way overcurrent did not shut outputs");
    AST_LATCH_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && en_w && fault_ff[fault_sup_pkg::F_OC] |=> fault_ff[fault_sup_pkg::F_OC])
        else $error("latched fault lost while enabled");
    AST_CLEAR: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && !en_s && state_ff == fault_sup_pkg::ST_FAULT |=> fault_ff == 5'h00)
        else $error("fault not cleared by enable low");
    AST_OV2_LS: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && ov2_watch_w && ov2_s && !rel_s |-> ##2 low_side_gate_a_o && !output_ok_flag_o)
        else $error("abs overvoltage did not turn low side on");
    AST_OV2_STICKY: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && ov2_lat_ff && por_s |=> ov2_lat_ff)
        else $error("abs overvoltage latch cleared without supply reset");
    AST_TT: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && ot_s |=> !thermal_throttle_n_o)
        else $error("throttle not asserted on over temperature");
    AST_OVS: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && ovs_cut_w && !ov2_dis_w |=> !low_side_gate_a_o && !low_side_gate_b_o)
        else $error("low side on during clamp");
    AST_SCALE: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && phcfg_w == fault_sup_pkg::PHCFG_THREE && !lps_n_s && !dslp_s
        |=> trip_scale_o == fault_sup_pkg::SCALE_TWO_3RD)
        else $error("trip level not scaled to two thirds");
    AST_FB2: assert property (@(posedge mclk_i) disable iff (reset_i)
        ce_i && phcfg_w != fault_sup_pkg::PHCFG_TWO |=> !aux_fb_switch_o)
        else $error("aux switch used outside two-phase config");
endmodule // regulator_fault_supervisor

// ===== verification/power_stage_model.sv
// behavioural power stage: output discharges while low-side gate a is held on
// assumes the bench raises ov_high_i while the output sits above 1.55 V
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic mclk_i,
    input  wire logic ov_high_i,
    input  wire logic low_side_gate_a_i,
    output logic      ov_abs_release_o
);
    logic [3:0] on_cnt_ff = 4'h0;
    initial ov_abs_release_o = 1'b0;
    // discharge takes nine cycles of low-side conduction, never instant
    always @(posedge mclk_i) begin
        if (ov_high_i || !low_side_gate_a_i)
            on_cnt_ff <= 4'h0;
        else if (on_cnt_ff != 4'h8)
            on_cnt_ff <= on_cnt_ff + 4'h1;
        if (ov_high_i)
            ov_abs_release_o <= 1'b0;
        else if (on_cnt_ff == 4'h8)
            ov_abs_release_o <= 1'b1;
    end
endmodule // power_stage_model

// ===== verification/tb_regulator_fault_supervisor.sv
// bench for the fault supervisor: apb tasks and fault sequences
// assumes the power stage model answers each discharge
`timescale 1ns/1ps
module tb_regulator_fault_supervisor;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, en = 0, sup = 1, psi_n = 1;
    logic oc = 0, woc = 0, imb = 0, uv = 0, ov1 = 0, ovh = 0, ot = 0, clamp = 0, zc = 0;
    logic lreq = 0, hreq = 0, rel, rdy, err, e1, ok, tri_st, hs, lsa, lsb, tt_n, aux, ss;
    logic ds = 0, pd = 0, vdn = 0, near = 1;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0, rd, prd;
    logic [1:0]  scl;
    logic [5:0]  trim;
    int          fails = 0, compares = 0, n;
    always #4 clk = ~clk;
    regulator_fault_supervisor #(.OC_QUAL_CYC(17'h14), .QUAL_CYC(17'h28))
        regulator_fault_supervisor_inst (.mclk_i(clk), .reset_i(rst), .ce_i(1'b1),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
        .prdata_o(rd), .pready_o(rdy), .pslverr_o(err), .regulator_enable_in_i(en),
        .supply_ok_i(sup), .low_power_state_n_i(psi_n), .deep_sleep_i(ds),
        .overcurrent_trip_i(oc), .way_overcurrent_i(woc), .imbalance_i(imb),
        .undervoltage_trip_i(uv), .overvoltage_trip_i(ov1), .ov_abs_high_i(ovh),
        .ov_abs_release_i(rel), .over_temp_i(ot), .comp_clamp_i(clamp), .zero_cross_i(zc),
        .phase_diode_i(pd), .vid_down_i(vdn), .vout_near_vid_i(near),
        .pwm_low_req_i(lreq), .pwm_high_req_i(hreq), .output_ok_flag_o(ok),
        .pwm_tristate_o(tri_st), .high_side_gate_o(hs), .low_side_gate_a_o(lsa),
        .low_side_gate_b_o(lsb), .thermal_throttle_n_o(tt_n), .aux_fb_switch_o(aux),
        .soft_start_o(ss), .trip_scale_o(scl), .zc_trim_o(trim));
    power_stage_model power_stage_model_inst (.mclk_i(clk), .ov_high_i(ovh),
        .low_side_gate_a_i(lsa), .ov_abs_release_o(rel));
    task finish_test;
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // bounded wait; a missing soft start ends the run
    task wait_ok;
        n = 0;
        while (ok !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            finish_test;
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            finish_test;
        end
        prd = rd;
        e1 = err;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task cycle_en;
        en <= 0;
        cyc(6);
        en <= 1;
        wait_ok;
    endtask
    initial begin
        #600000;
        fails++;
        finish_test;
    end
    initial begin
        cyc(16);
        rst <= 0;
        cyc(1);
        apb(0, 8'h00, 32'h0);
        chk("ctrl", {29'h0, fault_sup_pkg::CTRL_RESET}, prd);
        apb(0, 8'h10, 32'h0);
        chk("unmapped_err", 1, e1);
        en <= 1;
        cyc(8);
        chk("soft", 1, ss);
        wait_ok;
        apb(1, 8'h00, 32'h6);
        lreq <= 1;
        hreq <= 1;
        clamp <= 1;
        cyc(6);
        chk("ls_clamp", 0, lsa);
        chk("lsb_clamp", 0, lsb);
        chk("hs_run", 1, hs);
        clamp <= 0;
        cyc(6);
        chk("ls_free", 1, lsa);
        chk("lsb_free", 1, lsb);
        psi_n <= 0;
        clamp <= 1;
        cyc(6);
        chk("ls_psi", 1, lsa);
        chk("scale", fault_sup_pkg::SCALE_TWO_3RD, scl);
        clamp <= 0;
        lreq <= 0;
        apb(1, 8'h00, 32'h1);
        cyc(6);
        chk("aux_1ph", 0, aux);
        psi_n <= 1;
        cyc(6);
        chk("aux_2ph", 1, aux);
        ot <= 1;
        cyc(6);
        chk("tt", 0, tt_n);
        chk("ok_ot", 1, ok);
        ot <= 0;
        // long diode after a zero-crossing cut, then a short one
        ds <= 1;
        lreq <= 1;
        pd <= 1;
        cyc(6);
        chk("zc_on", 1, lsa);
        zc <= 1;
        cyc(30);
        chk("zc_cut", 0, lsa);
        chk("trim_dn", fault_sup_pkg::TRIM_RESET - 6'h01, trim);
        {lreq, pd, zc} <= 3'h0;
        cyc(4);
        lreq <= 1;
        cyc(6);
        lreq <= 0;
        cyc(8);
        chk("trim_up", fault_sup_pkg::TRIM_RESET, trim);
        vdn <= 1;
        near <= 0;
        cyc(4);
        vdn <= 0;
        ov1 <= 1;
        cyc(50);
        chk("ov_blank", 1, ok);
        ov1 <= 0;
        near <= 1;
        ds <= 0;
        oc <= 1;
        cyc(15);
        oc <= 0;
        cyc(2);
        oc <= 1;
        cyc(18);
        chk("oc_early", 1, ok);
        cyc(10);
        chk("oc", 0, ok);
        oc <= 0;
        for (int i = 0; i < 4; i++) begin
            cycle_en;
            {imb, uv, ov1, woc} <= 4'h8 >> i;
            cyc(i == 3 ? 6 : 50);
            chk("q_ok", 0, ok);
            chk("q_tri", 1, tri_st);
            chk("q_hs", 0, hs);
            {imb, uv, ov1, woc} <= 4'h0;
            cyc(8);
            chk("q_hold", 0, ok);
        end
        ovh <= 1;
        cyc(6);
        chk("ov2_ls", 1, lsa);
        ovh <= 0;
        cyc(16);
        chk("ov2_off", 0, lsa);
        ovh <= 1;
        cyc(6);
        chk("ov2_again", 1, lsa);
        ovh <= 0;
        en <= 0;
        cyc(6);
        en <= 1;
        cyc(1100);
        chk("ov2_hold", 0, ok);
        sup <= 0;
        cyc(6);
        sup <= 1;
        wait_ok;
        finish_test;
    end
endmodule // tb_regulator_fault_supervisor
